// ### rtl/pfs_pkg.sv
// package: constants, types and decode helpers of the strap and sync block
package pfs_pkg;
    localparam int unsigned CODE_W = 4;
    localparam int unsigned AXI_AW = 8;
    localparam int unsigned PHASE_W = 24;
    localparam logic [7:0] OFS_ILEAVE = 8'h00;
    localparam logic [7:0] OFS_FREQ = 8'h04;
    localparam logic [7:0] OFS_VNOM = 8'h08;
    localparam logic [7:0] OFS_LIM0 = 8'h0C;
    localparam logic [7:0] OFS_SCALE = 8'h2C;
    localparam logic [7:0] OFS_STAT = 8'h30;
    localparam logic [15:0] IL_STANDALONE = 16'h0000;
    localparam logic [15:0] IL_MASTER = 16'h0100;
    localparam logic [15:0] IL_SLAVE_0 = 16'h0120;
    localparam logic [15:0] IL_SLAVE_180 = 16'h0121;
    localparam logic [15:0] RST_ILEAVE = IL_MASTER;
    localparam logic [5:0] FREQ_N_MIN = 6'h06;
    localparam logic [5:0] FREQ_N_MAX = 6'h1E;
    localparam int unsigned FREQ_STEP_KHZ = 50;
    localparam int unsigned VOUT_LSB_PER_V = 512;
    localparam int unsigned MV_PER_V = 1000;
    localparam int unsigned PCT_FULL = 100;
    localparam int unsigned LINK_CLK_KHZ = 8000;
    localparam int unsigned SYNC_LOST_NS = 8000;
    localparam int unsigned SYNC_LOST_CYC = SYNC_LOST_NS * LINK_CLK_KHZ / 1000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned LIM_PCT [8] = '{90, 85, 115, 110, 90, 80, 95, 105};
    localparam int unsigned VOUT_MV [14] = '{600, 900, 950, 1000, 1050, 1200, 1250,
        1500, 1800, 2100, 2500, 3300, 5000, 12000};
    localparam int unsigned FREQ_N [15] = '{6, 8, 10, 11, 12, 13, 14, 15, 16, 17, 18,
        19, 20, 25, 30};

    typedef enum logic [1:0] {
        MODE_STANDALONE = 2'b00,
        MODE_MASTER = 2'b01,
        MODE_SLAVE_0 = 2'b10,
        MODE_SLAVE_180 = 2'b11
    } pfs_mode_e;

    typedef struct packed {
        pfs_mode_e mode;
        logic [PHASE_W-1:0] inc;
    } pfs_cfg_s;

    // open or shorted straps land on the nearest end of the table
    function automatic logic [15:0] vout_lin(input logic [CODE_W-1:0] code);
        int unsigned i;
        i = (code > 4'hD) ? 13 : int'(code);
        return 16'(VOUT_MV[i] * VOUT_LSB_PER_V / MV_PER_V);
    endfunction

    function automatic logic [5:0] freq_n(input logic [CODE_W-1:0] code);
        int unsigned i;
        i = (code > 4'hE) ? 14 : int'(code);
        return 6'(FREQ_N[i]);
    endfunction

    function automatic logic [15:0] lim_val(input logic [15:0] nom, input int unsigned idx);
        return 16'(int'(nom) * LIM_PCT[idx] / PCT_FULL);
    endfunction

    function automatic logic [PHASE_W-1:0] inc_of(input logic [5:0] n);
        longint unsigned t;
        t = (longint'(n) * FREQ_STEP_KHZ << PHASE_W) / LINK_CLK_KHZ;
        return PHASE_W'(t);
    endfunction

    function automatic logic il_legal(input logic [15:0] il);
        return il == IL_STANDALONE || il == IL_MASTER || il == IL_SLAVE_0 || il == IL_SLAVE_180;
    endfunction

    function automatic pfs_mode_e mode_of(input logic [15:0] il);
        return (il == IL_STANDALONE) ? MODE_STANDALONE : (il == IL_SLAVE_0) ? MODE_SLAVE_0 :
            (il == IL_SLAVE_180) ? MODE_SLAVE_180 : MODE_MASTER;
    endfunction
endpackage

// ### rtl/pfs_top.sv
// strap decode, overridable limits and switching sync with an AXI4-Lite register port
`timescale 1ns/1ps
// Summary of operation
// - At the first clock after reset the output strap code is decoded to one of fourteen nominal voltages from 0.60 V to 12.00 V.
// - The eight limits are derived from the nominal voltage as 90, 85, 115, 110, 90, 80, 95 and 105 percent.
// - The same decode loads the loop scale, and nominal and every limit stay writable in 1.953 mV steps.
// - The frequency strap code is sampled at power up and sets the default switching frequency.
// - Fifteen frequency codes map to 300 kHz up to 1500 kHz as tabulated.
// - Software may override the frequency in 50 kHz steps.
// - Standalone, master and two slave configurations exist, and master is the reset choice.
// - Writing the interleave register selects the configuration.
// - Value 0x0000 is standalone: sync pin released and switching self timed.
// - Value 0x0100 is master: sync pin driven with a 50 percent wave in phase with switching.
// - Value 0x0120 is slave in phase: switching follows and aligns with the external clock.
// - Value 0x0121 is slave at 180 degrees: switching edges sit half a period from the clock.
// - In either slave configuration a detected external clock overrides the configured frequency, else the own frequency runs.
module pfs_top #(
    parameter logic [pfs_pkg::CODE_W-1:0] SCALE_SPLIT_CODE = 4'hB,
    parameter logic [15:0] SCALE_LOW = 16'h0001,
    parameter logic [15:0] SCALE_HIGH = 16'h0004
) (
    // system clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // strap codes from the resistor reader, stable at reset release
    input wire logic [pfs_pkg::CODE_W-1:0] VOUT_STRAP_CODE,
    input wire logic [pfs_pkg::CODE_W-1:0] FREQ_STRAP_CODE,
    // AXI4-Lite slave
    input wire logic [pfs_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [pfs_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // link side: switching oscillator clock and sync pin
    input wire logic CLK_LINK,
    input wire logic SYNC_I,
    output logic SYNC_O,
    output logic SYNC_OE,
    output logic SW_PHASE
);
    import pfs_pkg::*;

    localparam logic [7:0] LOST = 8'(SYNC_LOST_CYC);
    localparam logic [PHASE_W-1:0] HALF = PHASE_W'(1) << (PHASE_W - 1);

    // system domain state
    logic loaded_q, loaded_d;
    logic [15:0] ileave_q, ileave_d, vnom_q, vnom_d, scale_q, scale_d;
    logic [5:0] freq_q, freq_d;
    logic [15:0] lim_q [8];
    logic [15:0] lim_d [8];
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    pfs_cfg_s sent_q, sent_d, cur_cfg;
    logic req_q, req_d, ack_s1, ack_s2, lk_s1, lk_s2;
    logic wr_go, wr_ok;
    logic [15:0] wval;

    // link domain state
    logic lrst_s1, lrst_s2, rq_s1, rq_s2, rq_s3, sy_s1, sy_s2, sy_s3;
    pfs_cfg_s cfg_l_q, cfg_l_d;
    logic [7:0] cnt_q, cnt_d, per_q, per_d;
    logic [PHASE_W-1:0] acc_q, acc_d;
    logic seen_q, seen_d, locked_q, locked_d, sw_q, sw_d, oe_q, oe_d;
    logic slave, ph180, edge_in;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        if (a >= OFS_LIM0 && a < OFS_SCALE) begin
            r = {16'h0, lim_q[3'((a - OFS_LIM0) >> 2)]};
        end else begin
            unique case (a)
                OFS_ILEAVE: r = {16'h0, ileave_q};
                OFS_FREQ: r = {26'h0, freq_q};
                OFS_VNOM: r = {16'h0, vnom_q};
                OFS_SCALE: r = {16'h0, scale_q};
                OFS_STAT: r = {27'h0, lk_s2, sent_q.mode, req_q ^ ack_s2, loaded_q};
                default: r = 32'h0;
            endcase
        end
        return r;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= OFS_STAT;
    endfunction

    assign S_AXI_AWREADY = !aw_q && !bv_q;
    assign S_AXI_WREADY = !w_q && !bv_q;
    assign S_AXI_ARREADY = !rv_q;
    assign S_AXI_BVALID = bv_q;
    assign S_AXI_BRESP = br_q;
    assign S_AXI_RVALID = rv_q;
    assign S_AXI_RDATA = rd_q;
    assign S_AXI_RRESP = rr_q;
    assign wr_go = aw_q && w_q && !bv_q;
    assign cur_cfg = '{mode: mode_of(ileave_q), inc: inc_of(freq_q)};

    always_comb begin
        loaded_d = 1'b1;
        ileave_d = ileave_q;
        freq_d = freq_q;
        vnom_d = vnom_q;
        scale_d = scale_q;
        lim_d = lim_q;
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q && !S_AXI_BREADY;
        br_d = br_q;
        rv_d = rv_q && !S_AXI_RREADY;
        rd_d = rd_q;
        rr_d = rr_q;
        wr_ok = 1'b1;
        wval = 16'h0;
        if (!loaded_q) begin
            vnom_d = vout_lin(VOUT_STRAP_CODE);
            for (int i = 0; i < 8; i++) begin
                lim_d[i] = lim_val(vout_lin(VOUT_STRAP_CODE), i);
            end
            scale_d = (VOUT_STRAP_CODE >= SCALE_SPLIT_CODE) ? SCALE_HIGH : SCALE_LOW;
            freq_d = freq_n(FREQ_STRAP_CODE);
        end
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_d = 1'b1;
            awa_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_d = 1'b1;
            wd_d = S_AXI_WDATA;
            ws_d = S_AXI_WSTRB;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            if (awa_q >= OFS_LIM0 && awa_q < OFS_SCALE && awa_q[1:0] == 2'b00) begin
                lim_d[3'((awa_q - OFS_LIM0) >> 2)] =
                    merge(lim_q[3'((awa_q - OFS_LIM0) >> 2)], wd_q, ws_q);
            end else begin
                unique case (awa_q)
                    OFS_ILEAVE: begin
                        wval = merge(ileave_q, wd_q, ws_q);
                        wr_ok = il_legal(wval);
                        if (wr_ok) ileave_d = wval;
                    end
                    OFS_FREQ: begin
                        wval = merge({10'h0, freq_q}, wd_q, ws_q);
                        wr_ok = wval >= {10'h0, FREQ_N_MIN} && wval <= {10'h0, FREQ_N_MAX};
                        if (wr_ok) freq_d = wval[5:0];
                    end
                    OFS_VNOM: vnom_d = merge(vnom_q, wd_q, ws_q);
                    OFS_SCALE: scale_d = merge(scale_q, wd_q, ws_q);
                    default: wr_ok = 1'b0;
                endcase
            end
            br_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rv_d = 1'b1;
            rd_d = rd_mux(S_AXI_ARADDR);
            rr_d = addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // config words cross by toggle handshake; sent_q holds still until acknowledged
    always_comb begin
        sent_d = sent_q;
        req_d = req_q;
        if (loaded_q && req_q == ack_s2 && cur_cfg != sent_q) begin
            sent_d = cur_cfg;
            req_d = !req_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        ack_s1 <= rq_s3;
        ack_s2 <= ack_s1;
        lk_s1 <= locked_q;
        lk_s2 <= lk_s1;
        if (!RST_N) begin
            loaded_q <= 1'b0;
            ileave_q <= RST_ILEAVE;
            freq_q <= FREQ_N_MIN;
            vnom_q <= 16'h0;
            scale_q <= 16'h0;
            lim_q <= '{default: 16'h0};
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= RESP_OKAY;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= RESP_OKAY;
            sent_q <= '{mode: MODE_STANDALONE, inc: '0};
            req_q <= 1'b0;
        end else begin
            loaded_q <= loaded_d;
            ileave_q <= ileave_d;
            freq_q <= freq_d;
            vnom_q <= vnom_d;
            scale_q <= scale_d;
            lim_q <= lim_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            sent_q <= sent_d;
            req_q <= req_d;
        end
    end

    // link domain
    assign slave = cfg_l_q.mode == MODE_SLAVE_0 || cfg_l_q.mode == MODE_SLAVE_180;
    assign ph180 = cfg_l_q.mode == MODE_SLAVE_180;
    assign edge_in = sy_s2 && !sy_s3;
    assign SW_PHASE = sw_q;
    assign SYNC_O = sw_q;
    assign SYNC_OE = oe_q;

    always_comb begin
        cfg_l_d = (rq_s2 != rq_s3) ? sent_q : cfg_l_q;
        acc_d = acc_q + cfg_l_q.inc;
        cnt_d = cnt_q;
        per_d = per_q;
        seen_d = seen_q;
        locked_d = locked_q;
        if (!slave) begin
            seen_d = 1'b0;
            locked_d = 1'b0;
            cnt_d = 8'h0;
        end else if (edge_in) begin
            cnt_d = 8'h0;
            per_d = cnt_q + 8'h1;
            seen_d = 1'b1;
            locked_d = seen_q;
            acc_d = ph180 ? HALF : '0; // own oscillator stays aligned for a clean fallback
        end else if (cnt_q != LOST) begin
            cnt_d = cnt_q + 8'h1;
        end else begin
            seen_d = 1'b0;
            locked_d = 1'b0;
        end
        if (locked_d) begin
            sw_d = (cnt_d < (per_q >> 1)) ^ ph180;
        end else begin
            sw_d = !acc_d[PHASE_W-1];
        end
        oe_d = cfg_l_q.mode == MODE_MASTER;
    end

    always_ff @(posedge CLK_LINK) begin
        lrst_s1 <= RST_N;
        lrst_s2 <= lrst_s1;
        rq_s1 <= req_q;
        rq_s2 <= rq_s1;
        rq_s3 <= rq_s2;
        sy_s1 <= SYNC_I;
        sy_s2 <= sy_s1;
        sy_s3 <= sy_s2;
        if (!lrst_s2) begin
            cfg_l_q <= '{mode: MODE_STANDALONE, inc: '0};
            acc_q <= '0;
            cnt_q <= 8'h0;
            per_q <= 8'h0;
            seen_q <= 1'b0;
            locked_q <= 1'b0;
            sw_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            cfg_l_q <= cfg_l_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            seen_q <= seen_d;
            locked_q <= locked_d;
            sw_q <= sw_d;
            oe_q <= oe_d;
        end
    end

    a_reset_master: assert property (@(posedge CLK_SYS) !RST_N |=> ileave_q == IL_MASTER)
        else $error("interleave not master after reset");
    a_vout_decode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !loaded_q |=> vnom_q == vout_lin($past(VOUT_STRAP_CODE)))
        else $error("nominal output not decoded from strap");
    a_limit_derive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !loaded_q |=> lim_q[2] == lim_val(vnom_q, 2) && lim_q[5] == lim_val(vnom_q, 5))
        else $error("derived limit wrong after strap load");
    a_freq_decode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !loaded_q |=> freq_q == freq_n($past(FREQ_STRAP_CODE)))
        else $error("frequency not decoded from strap");
    a_ileave_keep: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_go && awa_q == OFS_ILEAVE && !il_legal(merge(ileave_q, wd_q, ws_q))
        |=> $stable(ileave_q) && br_q == RESP_SLVERR)
        else $error("illegal interleave value taken");
    a_freq_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_go && awa_q == OFS_FREQ && ws_q[1:0] == 2'b11
        && wd_q[15:0] >= {10'h0, FREQ_N_MIN} && wd_q[15:0] <= {10'h0, FREQ_N_MAX}
        |=> freq_q == $past(wd_q[5:0]) && br_q == RESP_OKAY)
        else $error("frequency override not applied");
    a_standalone_rel: assert property (@(posedge CLK_LINK) disable iff (!lrst_s2)
        cfg_l_q.mode == MODE_STANDALONE |=> !SYNC_OE)
        else $error("sync pin driven in standalone");
    a_master_drive: assert property (@(posedge CLK_LINK) disable iff (!lrst_s2)
        cfg_l_q.mode == MODE_MASTER && $stable(cfg_l_q) |=> SYNC_OE && SYNC_O == SW_PHASE)
        else $error("master not driving sync with switching");
    a_slave_inphase: assert property (@(posedge CLK_LINK) disable iff (!lrst_s2)
        cfg_l_q.mode == MODE_SLAVE_0 && seen_q && edge_in && per_q > 8'h1 |=> SW_PHASE)
        else $error("in-phase slave not high at sync edge");
    a_slave_antiph: assert property (@(posedge CLK_LINK) disable iff (!lrst_s2)
        cfg_l_q.mode == MODE_SLAVE_180 && seen_q && edge_in && per_q > 8'h1 |=> !SW_PHASE)
        else $error("180 slave not low at sync edge");
    a_lost_fallback: assert property (@(posedge CLK_LINK) disable iff (!lrst_s2)
        slave && cnt_q == LOST && !edge_in |=> !locked_q)
        else $error("lost sync clock not detected");
endmodule // pfs_top

// ### tb/pfs_sync_src.sv
// partner model: a neighbouring converter driving a sync clock onto the shared pin
`timescale 1ns/1ps
module pfs_sync_src (
    // link clock and control from the bench
    input wire logic clk_link,
    input wire logic en,
    input wire logic [7:0] half,
    // pin drive
    output logic pin_o,
    output logic pin_oe
);
    logic [7:0] cnt_q;
    initial begin
        cnt_q = 8'h00;
        pin_o = 1'b0;
    end
    // when disabled the pin is released; the frequency resistor then pulls it low
    assign pin_oe = en;
    always @(posedge clk_link) begin
        if (!en) begin
            cnt_q <= 8'h00;
            pin_o <= 1'b0;
        end else if (cnt_q + 8'h01 >= half) begin
            cnt_q <= 8'h00;
            pin_o <= ~pin_o;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // pfs_sync_src

// ### tb/tb_pinstrap_freq_sync_config.sv
// self-checking bench: strap decode, register overrides and switching sync modes
`timescale 1ns/1ps
module tb_pinstrap_freq_sync_config;
    import pfs_pkg::*;
    logic clk_sys, clk_link, rst_n, awvalid, wvalid, bready, arvalid, rready, src_en;
    logic [3:0] vcode, fcode, wstrb;
    logic [7:0] awaddr, araddr, lfsr, src_half;
    logic [31:0] wdata, rdata;
    logic awready, wready, bvalid, arready, rvalid, sync_o, sync_oe, sw_phase, src_o, src_oe;
    logic [1:0] bresp, rresp;
    wire sync_pin;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    int miscompares = 0;
    int cmp_count = 0;

    // pin resistor to ground: a released pin reads low
    assign sync_pin = sync_oe ? sync_o : (src_oe ? src_o : 1'b0);

    pfs_top u_pfs_top (.CLK_SYS(clk_sys), .RST_N(rst_n), .VOUT_STRAP_CODE(vcode),
        .FREQ_STRAP_CODE(fcode), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CLK_LINK(clk_link), .SYNC_I(sync_pin), .SYNC_O(sync_o), .SYNC_OE(sync_oe),
        .SW_PHASE(sw_phase));
    pfs_sync_src u_pfs_sync_src (.clk_link(clk_link), .en(src_en), .half(src_half),
        .pin_o(src_o), .pin_oe(src_oe));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #7;
        forever #62.5 clk_link = ~clk_link;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [33:0] okv(input logic [15:0] d);
        return {RESP_OKAY, 16'h0000, d};
    endfunction

    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        miscompares++;
        $display("wrong value %s expected response seen none", what);
        stop_test();
    endtask

    // response watcher: oldest note against each answer
    always @(posedge clk_sys) begin
        if (rvalid && rready && rd_q.size() > 0) begin
            check("read data", {rresp, rdata}, rd_q.pop_front());
        end
        if (bvalid && bready && wr_q.size() > 0) begin
            check("write resp", {32'h0, bresp}, {32'h0, wr_q.pop_front()});
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        n = 0;
        wr_q.push_back(er);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            n++;
            if (n > 50) begin
                timeout("write");
            end
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        int n;
        n = 0;
        rd_q.push_back(exp);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            n++;
            if (n > 50) begin
                timeout("read");
            end
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask

    // link side copies reset through two flops, so hold it past three link edges
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask

    // counts toggles and high time of the switching phase over 400 link cycles
    task automatic watch_pin(input logic oe_exp, input int tog_exp);
        int hi;
        int tog;
        logic last;
        hi = 0;
        tog = 0;
        repeat (20) @(posedge clk_link);
        last = sw_phase;
        repeat (400) begin
            @(negedge clk_link);
            hi += int'(sw_phase);
            tog += int'(sw_phase != last);
            last = sw_phase;
            check("sync pin", {33'h0, sync_pin}, {33'h0, oe_exp ? sw_phase : src_o});
        end
        check("pin enable", {33'h0, sync_oe}, {33'h0, oe_exp});
        check("duty", {33'h0, hi > 180 && hi < 220}, 34'h1);
        check("rate", {33'h0, tog >= tog_exp - 2 && tog <= tog_exp + 2}, 34'h1);
    endtask

    task automatic slave_phase(input logic [15:0] il, input logic [31:0] st, input logic ph);
        int n;
        wr(OFS_ILEAVE, il, RESP_OKAY);
        repeat (200) @(posedge clk_link);
        rd(OFS_STAT, {RESP_OKAY, st});
        for (n = 0; n < 100 && src_o !== 1'b0; n++) @(negedge clk_link);
        if (n >= 100) begin
            timeout("sync low");
        end
        for (n = 0; n < 100 && src_o !== 1'b1; n++) @(negedge clk_link);
        if (n >= 100) begin
            timeout("sync high");
        end
        repeat (6) @(posedge clk_link);
        @(negedge clk_link);
        check("switching phase", {33'h0, sw_phase}, {33'h0, ph});
        watch_pin(1'b0, 31);
        $display("test slave mode %h done", il);
    endtask

    initial begin
        int nom;
        int fi;
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, src_en} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        vcode = 4'h0;
        fcode = 4'h0;
        wstrb = 4'h3;
        lfsr = 8'h3C;
        src_half = 8'h0D;
        for (int v = 0; v < 16; v++) begin
            lfsr = lfsr_next(lfsr);
            vcode <= 4'(v);
            fcode <= lfsr[3:0];
            do_reset();
            nom = VOUT_MV[v > 13 ? 13 : v] * VOUT_LSB_PER_V / MV_PER_V;
            fi = (lfsr[3:0] > 4'hE) ? 14 : int'(lfsr[3:0]);
            rd(OFS_VNOM, okv(16'(nom)));
            for (int i = 0; i < 8; i++) begin
                rd(OFS_LIM0 + 8'(4 * i), okv(16'(nom * LIM_PCT[i] / PCT_FULL)));
            end
            rd(OFS_FREQ, okv(16'(FREQ_N[fi])));
            rd(OFS_SCALE, okv((4'(v) >= u_pfs_top.SCALE_SPLIT_CODE) ?
                u_pfs_top.SCALE_HIGH : u_pfs_top.SCALE_LOW));
        end
        $display("test strap decode done");
        wr(OFS_FREQ, 16'h001E, RESP_OKAY);
        wr(OFS_FREQ, 16'h001F, RESP_SLVERR);
        wr(OFS_FREQ, 16'h0005, RESP_SLVERR);
        rd(OFS_FREQ, okv(16'h001E));
        wr(OFS_VNOM, 16'h0800, RESP_OKAY);
        wr(OFS_LIM0 + 8'h1C, 16'h0ABC, RESP_OKAY);
        rd(OFS_VNOM, okv(16'h0800));
        rd(OFS_LIM0 + 8'h1C, okv(16'h0ABC));
        wstrb <= 4'h1;
        wr(OFS_VNOM, 16'h12AB, RESP_OKAY);
        wstrb <= 4'h2;
        wr(OFS_LIM0, 16'h34CD, RESP_OKAY);
        wstrb <= 4'h3;
        rd(OFS_VNOM, okv(16'h08AB));
        rd(OFS_LIM0, okv({8'h34, 8'(nom * LIM_PCT[0] / PCT_FULL)}));
        rd(8'h34, {RESP_SLVERR, 32'h0});
        rd(8'h05, {RESP_SLVERR, 32'h0});
        wr(OFS_STAT, 16'h0000, RESP_SLVERR);
        rd(OFS_ILEAVE, okv(IL_MASTER));
        wr(OFS_ILEAVE, 16'h0101, RESP_SLVERR);
        rd(OFS_ILEAVE, okv(IL_MASTER));
        $display("test register overrides done");
        fcode <= 4'h0; // same strap as the neighbour
        do_reset();
        watch_pin(1'b1, 30);
        wr(OFS_FREQ, 16'h000A, RESP_OKAY);
        watch_pin(1'b1, 50);
        wr(OFS_ILEAVE, IL_STANDALONE, RESP_OKAY);
        watch_pin(1'b0, 50);
        $display("test master and standalone done");
        src_en <= 1'b1;
        slave_phase(IL_SLAVE_0, 32'h00000019, 1'b1);
        slave_phase(IL_SLAVE_180, 32'h0000001D, 1'b0);
        src_en <= 1'b0;
        repeat (100) @(posedge clk_link);
        rd(OFS_STAT, {RESP_OKAY, 32'h0000000D});
        watch_pin(1'b0, 50);
        $display("test sync loss done");
        stop_test();
    end
endmodule // tb_pinstrap_freq_sync_config
